// ==== afo_pkg.sv ====
// shared constants, register map and state encoding of the output formatter
`default_nettype none
package afo_pkg;
  localparam int         AXI_AW      = 4;     // register address width
  localparam logic [3:0] REG_CTRL    = 4'h0;  // control register byte address
  localparam logic [3:0] REG_STAT    = 4'h4;  // status register byte address
  localparam int         CTRL_W      = 8;     // implemented control bits
  localparam logic [7:0] CTRL_RST    = 8'h00; // lvds, offset binary, register mode
  localparam int         CTRL_STD    = 0;     // output_standard_select, 1 = cmos
  localparam int         CTRL_CODE   = 1;     // sample_coding_select, 1 = twos
  localparam int         CTRL_PINCFG = 2;     // 1 = take modes from the pins
  localparam int         CTRL_PM_LSB = 4;     // power_mode_field position
  localparam int         PM_W        = 4;     // power_mode_field width
  localparam logic [3:0] PM_MUX      = 4'hF;  // multiplexed output code
  localparam int         STAT_W      = 8;     // implemented status bits
  localparam int         FSP_STD     = 0;     // format_select_pin bit for standard
  localparam int         FSP_CODE    = 1;     // format_select_pin bit for coding
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // axi okay
  localparam logic [1:0] RESP_DECERR = 2'h3;  // axi decode error
  localparam int         SLOT_CYC    = 2;     // aclk cycles per output half period
  localparam int         SLOT_W      = 2;     // slot counter width
  localparam int         FIFO_DEPTH  = 8;     // sample pairs buffered

  // output sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DDR_RISE = 3'b001,
    ST_DDR_FALL = 3'b010,
    ST_CM_LOW   = 3'b011,
    ST_CM_HIGH  = 3'b100,
    ST_MX_LOW   = 3'b101,
    ST_MX_HIGH  = 3'b110
  } afo_state_t;
endpackage
`default_nettype wire

// ==== afo_stream_if.sv ====
// valid/ready stream carrying sample pairs between formatter and fifo
`timescale 1ns/1ps
`default_nettype none
interface afo_stream_if #(parameter int W = 28);
  logic [W-1:0] data;  // payload
  logic         valid; // source offers data
  logic         ready; // sink accepts data
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== afo_fifo.sv ====
// sample pair fifo with a registered read stage
`timescale 1ns/1ps
`default_nettype none
module afo_fifo #(
  parameter int W     = 28,
  parameter int DEPTH = 8
) (
  input wire logic    aclk,
  input wire logic    aresetn,
  afo_stream_if.snk   wr,
  afo_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wp;         // write pointer
  logic [AW-1:0] rp;         // read pointer
  logic [AW:0]   cnt;        // words held in storage

  // honest full: refuse when storage is full
  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  wire push = wr.valid & wr.ready;
  // refill the read register when it is free or being taken
  wire load = (cnt != '0) & (~rd.valid | rd.ready);

  // storage write, no reset needed
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp] <= wr.data;
    end
  end

  // pointers, count and read register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp       <= '0;
      rp       <= '0;
      cnt      <= '0;
      rd.valid <= 1'h0;
      rd.data  <= '0;
    end else begin
      if (push) wp <= wp + 1'h1;
      if (load) begin
        rp      <= rp + 1'h1;
        rd.data <= mem[rp];
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
      if (load) rd.valid <= 1'h1;
      else if (rd.ready) rd.valid <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// ==== afo_coder.sv ====
// per-channel saturation and output coding of one sample
`timescale 1ns/1ps
`default_nettype none
module afo_coder #(
  parameter int DATA_W = 14
) (
  input  wire logic [DATA_W-1:0] raw,
  input  wire logic              ovr_pos,
  input  wire logic              ovr_neg,
  input  wire logic              twos,
  output logic      [DATA_W-1:0] code
);
  // overdrive forces full scale in offset binary first
  wire [DATA_W-1:0] sat = ovr_pos ? {DATA_W{1'h1}} : ovr_neg ? '0 : raw; // RQ16 RQ17
  // twos complement is offset binary with msb flipped
  assign code = {sat[DATA_W-1] ^ twos, sat[DATA_W-2:0]}; // RQ15 RQ19
endmodule
`default_nettype wire

// ==== afo_formatter.sv ====
// dual channel output formatter: coding, buffering, ddr lvds or cmos drive
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1 - each channel word delivered with aligned clock
// RQ2 - pick lvds or cmos from register/pin
// RQ3 - lvds carries two bits per pair
// RQ4 - even bits on rise, odd on fall
// RQ5 - receiver samples both ddr clock edges
// RQ6 - cmos one pin per bit, per cycle
// RQ7 - cmos only up to 210 msps
// RQ8 - below 150 msps latch on cmos clock
// RQ9 - above 150 msps use delayed sample clock
// RQ10 - mux mode: a bus carries, b floats
// RQ11 - mux mode sends two samples per period
// RQ12 - mux mode only with cmos standard
// RQ13 - mux mode only below 65 msps
// RQ14 - mux selected by register or pins
// RQ15 - coding twos or offset binary selectable
// RQ16 - positive overdrive gives positive full scale
// RQ17 - negative overdrive gives negative full scale
// RQ18 - mux when field 1111 or pins high
// RQ19 - twos equals offset binary msb inverted
module afo_formatter
  import afo_pkg::*;
#(
  parameter int DATA_W = 14,
  parameter int DEPTH  = FIFO_DEPTH
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                sample_clock,
  input  wire logic [DATA_W-1:0]   raw_a,
  input  wire logic [DATA_W-1:0]   raw_b,
  input  wire logic [1:0]          ovr_pos,
  input  wire logic [1:0]          ovr_neg,
  input  wire logic [1:0]          format_select_pin,
  input  wire logic [2:0]          mode_control_pins,
  output logic                     ddr_output_clock,
  output logic [DATA_W/2-1:0]      lvds_a,
  output logic [DATA_W/2-1:0]      lvds_b,
  output logic                     cmos_output_clock,
  output logic [DATA_W-1:0]        channel_a_bus,
  output logic [DATA_W-1:0]        channel_b_bus,
  output logic                     channel_b_bus_oe
);
  localparam int PAIRS = DATA_W / 2;  // differential pairs per channel
  localparam int SW    = 2*DATA_W + 10; // synchronised pin bits
  localparam int PW    = 2*DATA_W;    // sample pair width

  // pick even or odd bits of a word for the lvds pairs
  function automatic logic [PAIRS-1:0] pick_bits(input logic [DATA_W-1:0] w, input logic odd);
    logic [PAIRS-1:0] r;
    r = '0;
    for (int i = 0; i < PAIRS; i++) r[i] = w[2*i + int'(odd)];
    return r;
  endfunction

  // ---- pin synchroniser ----
  logic [SW-1:0] pin_s1;    // first stage, read only by second
  logic [SW-1:0] pin_s2;    // second stage, safe to use
  logic          sclk_d;    // delayed sampling clock for edge find

  // two flops on every pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      sclk_d <= 1'h0;
    end else begin
      pin_s1 <= {sample_clock, ovr_neg, ovr_pos, raw_b, raw_a, format_select_pin, mode_control_pins};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2[SW-1];
    end
  end

  // unpack synchronised pins
  wire [2:0]        mcp_s   = pin_s2[2:0];
  wire [1:0]        fsp_s   = pin_s2[4:3];
  wire [DATA_W-1:0] raw_a_s = pin_s2[5 +: DATA_W];
  wire [DATA_W-1:0] raw_b_s = pin_s2[5+DATA_W +: DATA_W];
  wire [1:0]        ovp_s   = pin_s2[5+PW +: 2];
  wire [1:0]        ovn_s   = pin_s2[7+PW +: 2];
  wire              samp_edge = pin_s2[SW-1] & ~sclk_d; // new sample available

  // ---- control register and mode resolution ----
  logic [CTRL_W-1:0] ctrl;      // software control bits
  logic              ovr_flag;  // sticky fifo overrun
  wire              ctl_std = ctrl[CTRL_STD];
  wire              ctl_code = ctrl[CTRL_CODE];
  wire              pin_cfg = ctrl[CTRL_PINCFG];
  wire [PM_W-1:0]   ctl_pm = ctrl[CTRL_PM_LSB +: PM_W];
  // standard and coding from register or pin
  wire eff_cmos = pin_cfg ? fsp_s[FSP_STD] : ctl_std;   // RQ2
  wire eff_twos = pin_cfg ? fsp_s[FSP_CODE] : ctl_code; // RQ15
  // mux request from field or all control pins high
  wire mux_req = pin_cfg ? (&mcp_s) : (ctl_pm == PM_MUX); // RQ14 RQ18
  // mux only honoured in cmos
  wire eff_mux = mux_req & eff_cmos; // RQ12

  // ---- coding of both channels ----
  logic [DATA_W-1:0] raw_s  [2]; // channel raw codes
  logic [DATA_W-1:0] code_s [2]; // coded channel words
  assign raw_s[0] = raw_a_s;
  assign raw_s[1] = raw_b_s;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      afo_coder #(.DATA_W(DATA_W)) u_coder (
        .raw     (raw_s[ch]),
        .ovr_pos (ovp_s[ch]),
        .ovr_neg (ovn_s[ch]),
        .twos    (eff_twos),
        .code    (code_s[ch])
      );
    end
  endgenerate

  // ---- capture into fifo ----
  afo_stream_if #(.W(PW)) in_if ();  // capture to fifo
  afo_stream_if #(.W(PW)) out_if (); // fifo to sequencer
  logic          cap_valid; // one-cycle offer per sample
  logic [PW-1:0] cap_data;  // {channel b, channel a}
  assign in_if.valid = cap_valid;
  assign in_if.data  = cap_data;

  // latch coded pair at each sampling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_valid <= 1'h0;
      cap_data  <= '0;
    end else begin
      cap_valid <= samp_edge;
      if (samp_edge) cap_data <= {code_s[1], code_s[0]};
    end
  end

  afo_fifo #(.W(PW), .DEPTH(DEPTH)) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (in_if),
    .rd      (out_if)
  );

  // ---- output sequencer ----
  afo_state_t        state;      // current slot
  afo_state_t        next_state; // slot after this edge
  logic [SLOT_W-1:0] slot_cnt;   // cycles spent in slot
  logic [DATA_W-1:0] word_a;     // channel a word on the wires
  logic [DATA_W-1:0] word_b;     // channel b word on the wires
  logic              cur_cmos;   // standard of word in flight
  logic              cur_mux;    // mux mode of word in flight

  wire slot_done = (slot_cnt == SLOT_W'(SLOT_CYC - 1));
  // last slot of a word, a new word may start
  wire last_slot = (state == ST_DDR_FALL) | (state == ST_MX_HIGH) | ((state == ST_CM_HIGH) & ~cur_mux);
  wire word_end  = (state == ST_IDLE) | (slot_done & last_slot);
  wire pop       = out_if.valid & word_end;
  assign out_if.ready = pop;
  wire afo_state_t start_st = eff_cmos ? ST_CM_LOW : ST_DDR_RISE;
  // values the wires take after this edge
  wire [DATA_W-1:0] nw_a   = pop ? out_if.data[DATA_W-1:0] : word_a;
  wire [DATA_W-1:0] nw_b   = pop ? out_if.data[PW-1:DATA_W] : word_b;
  wire              nw_mux = pop ? eff_mux : cur_mux;

  // slot sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (out_if.valid) next_state = start_st;
      end
      ST_DDR_RISE: begin
        if (slot_done) next_state = ST_DDR_FALL; // RQ3
      end
      ST_CM_LOW: begin
        if (slot_done) next_state = ST_CM_HIGH;
      end
      ST_CM_HIGH: begin
        if (slot_done && cur_mux) next_state = ST_MX_LOW; // RQ11
        else if (slot_done) next_state = out_if.valid ? start_st : ST_IDLE;
      end
      ST_MX_LOW: begin
        if (slot_done) next_state = ST_MX_HIGH;
      end
      ST_DDR_FALL, ST_MX_HIGH: begin
        if (slot_done) next_state = out_if.valid ? start_st : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // decoded output values for the next slot
  wire in_ddr_r = (next_state == ST_DDR_RISE);
  wire in_ddr_f = (next_state == ST_DDR_FALL);
  wire in_cm    = (next_state == ST_CM_LOW) | (next_state == ST_CM_HIGH);
  wire in_mx    = (next_state == ST_MX_LOW) | (next_state == ST_MX_HIGH);
  wire next_cmos_clk = (next_state == ST_CM_HIGH) | (next_state == ST_MX_HIGH);
  // even bits with rising clock, odd with falling
  wire [PAIRS-1:0] next_lvds_a = in_ddr_r ? pick_bits(nw_a, 1'h0) : in_ddr_f ? pick_bits(nw_a, 1'h1) : '0; // RQ4
  wire [PAIRS-1:0] next_lvds_b = in_ddr_r ? pick_bits(nw_b, 1'h0) : in_ddr_f ? pick_bits(nw_b, 1'h1) : '0; // RQ4
  // a bus carries a, then b in mux mode
  wire [DATA_W-1:0] next_bus_a = in_cm ? nw_a : in_mx ? nw_b : '0; // RQ6 RQ11
  wire              next_b_oe  = in_cm & ~nw_mux; // RQ10
  wire [DATA_W-1:0] next_bus_b = next_b_oe ? nw_b : '0;

  // state, slot counter and word hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      slot_cnt <= '0;
      word_a   <= '0;
      word_b   <= '0;
      cur_cmos <= 1'h0;
      cur_mux  <= 1'h0;
    end else begin
      state    <= next_state;
      slot_cnt <= (next_state != state || state == ST_IDLE) ? '0 : slot_cnt + 1'h1;
      if (pop) begin
        word_a   <= nw_a;
        word_b   <= nw_b;
        cur_cmos <= eff_cmos; // RQ2
        cur_mux  <= eff_mux;  // RQ12
      end
    end
  end

  // registered pin drivers, clock aligned with data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ddr_output_clock  <= 1'h0;
      lvds_a            <= '0;
      lvds_b            <= '0;
      cmos_output_clock <= 1'h0;
      channel_a_bus     <= '0;
      channel_b_bus     <= '0;
      channel_b_bus_oe  <= 1'h0;
    end else begin
      ddr_output_clock  <= in_ddr_r;    // RQ1 RQ5
      lvds_a            <= next_lvds_a; // RQ3
      lvds_b            <= next_lvds_b;
      cmos_output_clock <= next_cmos_clk; // RQ1 RQ8
      channel_a_bus     <= next_bus_a;
      channel_b_bus     <= next_bus_b;
      channel_b_bus_oe  <= next_b_oe; // RQ10
    end
  end

  // ---- axi4-lite slave ----
  logic [AXI_AW-1:0] aw_addr_q; // held write address
  logic [31:0]       w_data_q;  // held write data
  logic [3:0]        w_strb_q;  // held byte enables
  wire do_wr   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_ctrl = (aw_addr_q == REG_CTRL);
  wire wr_stat = (aw_addr_q == REG_STAT);
  wire ar_ctrl = (s_axi_araddr == REG_CTRL);
  wire ar_stat = (s_axi_araddr == REG_STAT);
  wire [STAT_W-1:0] stat_word = {1'h0, state, channel_b_bus_oe, cur_mux, cur_cmos, ovr_flag};
  wire [31:0] rd_word = ar_ctrl ? 32'(ctrl) : ar_stat ? 32'(stat_word) : 32'h0;
  wire ovr_set = cap_valid & ~in_if.ready; // sample dropped on full fifo
  wire ovr_clr = do_wr & wr_stat & w_strb_q[0] & w_data_q[0];

  // write channels taken independently, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h1;
      s_axi_wready  <= 1'h1;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'h0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'h0;
        s_axi_awready <= 1'h1;
        s_axi_wready  <= 1'h1;
      end
    end
  end

  // control store and sticky overrun, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= CTRL_RST;
      ovr_flag <= 1'h0;
    end else begin
      if (do_wr && wr_ctrl && w_strb_q[0]) ctrl <= w_data_q[CTRL_W-1:0];
      ovr_flag <= ovr_set | (ovr_flag & ~ovr_clr);
    end
  end

  // read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (ar_ctrl || ar_stat) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'h0;
      s_axi_arready <= 1'h1;
    end
  end

  // ---- checks ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ddr_even_rise: assert property ($rose(ddr_output_clock) |-> // RQ4
    lvds_a == pick_bits(word_a, 1'h0) && lvds_b == pick_bits(word_b, 1'h0))
    else $error("even bits not on rising ddr clock");
  a_ddr_odd_fall: assert property (state == ST_DDR_RISE && slot_done |=> // RQ4
    !ddr_output_clock && lvds_a == pick_bits(word_a, 1'h1))
    else $error("odd bits not on falling ddr clock");
  a_ddr_two_bits: assert property ($rose(ddr_output_clock) |-> // RQ3
    ddr_output_clock[*2] ##1 !ddr_output_clock[*2])
    else $error("ddr period not two bit slots");
  a_cmos_whole_word: assert property (state == ST_CM_LOW |-> // RQ6
    channel_a_bus == word_a && !cmos_output_clock)
    else $error("cmos bus not showing whole word");
  a_mux_b_float: assert property (cur_mux && state != ST_IDLE |-> !channel_b_bus_oe) // RQ10
    else $error("channel b driven in mux mode");
  a_mux_second_word: assert property (state == ST_CM_HIGH && cur_mux && slot_done |=> // RQ11
    state == ST_MX_LOW && channel_a_bus == word_b)
    else $error("second sample missing in mux mode");
  a_mux_cmos_only: assert property (state == ST_DDR_RISE |-> !cur_mux) // RQ12
    else $error("mux mode with lvds");
  a_mux_select: assert property (pop |=> cur_mux == ($past(mux_req) && $past(eff_cmos))) // RQ14 RQ18
    else $error("mux selection wrong");
  a_std_select: assert property (pop |=> cur_cmos == $past(eff_cmos)) // RQ2
    else $error("output standard not latched");
  a_pos_full: assert property (samp_edge && ovp_s[0] |=> // RQ16
    cap_data[DATA_W-1:0] == {!$past(eff_twos), {(DATA_W-1){1'h1}}})
    else $error("positive full scale wrong");
  a_neg_full: assert property (samp_edge && !ovp_s[0] && ovn_s[0] |=> // RQ17
    cap_data[DATA_W-1:0] == {$past(eff_twos), {(DATA_W-1){1'h0}}})
    else $error("negative full scale wrong");
  a_twos_msb: assert property (samp_edge && !ovp_s[0] && !ovn_s[0] |=> // RQ19
    cap_data[DATA_W-1] == ($past(raw_a_s[DATA_W-1]) ^ $past(eff_twos)))
    else $error("coding msb wrong");

  c_ddr_stream: cover property (state == ST_DDR_FALL ##1 state == ST_DDR_RISE);
  c_cmos_word: cover property (state == ST_CM_HIGH && !cur_mux);
  c_mux_pair: cover property (state == ST_MX_HIGH);
  c_overrun: cover property (ovr_set);
endmodule
`default_nettype wire

// ==== afo_rx_model.sv ====
// receiving logic model: rebuilds sample words from the ddr or cmos output pins
`timescale 1ns/1ps
`default_nettype none
module afo_rx_model #(
  parameter int W = 14
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           ddr_clk,
  input  wire logic [W/2-1:0] lvds_a,
  input  wire logic [W/2-1:0] lvds_b,
  input  wire logic           cmos_clk,
  input  wire logic [W-1:0]   bus_a,
  input  wire logic [W-1:0]   bus_b,
  input  wire logic           b_oe,
  output logic      [W-1:0]   word_a,
  output logic      [W-1:0]   word_b,
  output logic                mux_seen,
  output int                  n_words
);
  logic         dprev; // last ddr clock level
  logic         cprev; // last cmos clock level
  logic         half;  // first half of a multiplexed word held
  logic [W-1:0] ea;    // even bits of a, or first mux word
  logic [W-1:0] eb;    // even bits of b

  // capture on both ddr edges, on the cmos rising edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      dprev    <= 1'b0;
      cprev    <= 1'b0;
      half     <= 1'b0;
      mux_seen <= 1'b0;
      n_words  <= 0;
    end else begin
      dprev <= ddr_clk;
      cprev <= cmos_clk;
      // even bits arrive with the rising ddr edge
      if (ddr_clk && !dprev) begin
        for (int i = 0; i < W/2; i++) begin
          ea[2*i] <= lvds_a[i];
          eb[2*i] <= lvds_b[i];
        end
      end
      // odd bits with the falling edge complete the word
      if (!ddr_clk && dprev) begin
        for (int i = 0; i < W/2; i++) begin
          word_a[2*i]   <= ea[2*i];
          word_b[2*i]   <= eb[2*i];
          word_a[2*i+1] <= lvds_a[i];
          word_b[2*i+1] <= lvds_b[i];
        end
        mux_seen <= 1'b0;
        n_words  <= n_words + 1;
      end
      // cmos words latched on the rising output clock
      if (cmos_clk && !cprev) begin
        if (b_oe) begin
          word_a   <= bus_a;
          word_b   <= bus_b;
          mux_seen <= 1'b0;
          n_words  <= n_words + 1;
        end else if (!half) begin
          ea   <= bus_a;
          half <= 1'b1;
        end else begin
          word_a   <= ea;
          word_b   <= bus_a;
          half     <= 1'b0;
          mux_seen <= 1'b1;
          n_words  <= n_words + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_adc_dual_output_formatter.sv ====
// testbench: register access over axi4-lite and sample words through every output mode
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module tb_adc_dual_output_formatter;
  import afo_pkg::*;
  localparam int DW = 14; // sample width
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sample_clock;
  logic awready, wready, bvalid, arready, rvalid, ddr_clk, cmos_clk, b_oe, mux_seen;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, ovr_pos, ovr_neg, fsp, rsp;
  logic [2:0] mcp;
  logic [DW-1:0] raw_a, raw_b, bus_a, bus_b, word_a, word_b;
  logic [DW/2-1:0] lvds_a, lvds_b;
  logic [31:0] rd;
  int n_errors = 0, comparisons = 0, n_words;
  // mode table: control word, pin levels
  logic [7:0] ctl [9] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'hF1, 8'hF3, 8'hF0, 8'h04, 8'h04};
  logic [1:0] fpt [9] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};

  afo_formatter #(.DATA_W(DW)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_clock(sample_clock), .raw_a(raw_a), .raw_b(raw_b), .ovr_pos(ovr_pos), .ovr_neg(ovr_neg),
    .format_select_pin(fsp), .mode_control_pins(mcp), .ddr_output_clock(ddr_clk), .lvds_a(lvds_a),
    .lvds_b(lvds_b), .cmos_output_clock(cmos_clk), .channel_a_bus(bus_a), .channel_b_bus(bus_b),
    .channel_b_bus_oe(b_oe));
  afo_rx_model #(.W(DW)) rx (.aclk(aclk), .aresetn(aresetn), .ddr_clk(ddr_clk), .lvds_a(lvds_a),
    .lvds_b(lvds_b), .cmos_clk(cmos_clk), .bus_a(bus_a), .bus_b(bus_b), .b_oe(b_oe),
    .word_a(word_a), .word_b(word_b), .mux_seen(mux_seen), .n_words(n_words));

  // 40 mhz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // expected code: saturation then msb flip for twos complement
  function automatic logic [DW-1:0] exp_code(input logic [DW-1:0] r, input logic p, n, tw);
    logic [DW-1:0] s;
    s = p ? {DW{1'b1}} : (n ? {DW{1'b0}} : r);
    return tw ? {~s[DW-1], s[DW-2:0]} : s;
  endfunction

  // one axi write, both channels offered together
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; wstrb <= 4'hF; bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    r = 2'hX;
    // wait for the answer; only the watchdog ends a hang
    forever begin
      @(posedge aclk);
      if (aw && awready) begin awvalid <= 1'b0; aw = 1'b0; end
      if (w && wready) begin wvalid <= 1'b0; w = 1'b0; end
      if (bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
  endtask

  // one axi read
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    d = 32'hX;
    r = 2'hX;
    // wait for the answer; only the watchdog ends a hang
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
    end
  endtask

  // one sample pair, sample clock high for 4 cycles (100 ns), then compare what the receiver rebuilt
  task automatic send_check(input logic [DW-1:0] a, b, input logic [1:0] p, n, input logic tw, mx);
    int k0;
    k0 = n_words;
    @(posedge aclk);
    raw_a <= a; raw_b <= b; ovr_pos <= p; ovr_neg <= n;
    repeat (4) @(posedge aclk);
    sample_clock <= 1'b1;
    repeat (4) @(posedge aclk);
    sample_clock <= 1'b0;
    for (int t = 0; t < 100 && n_words == k0; t++) @(posedge aclk);
    `CHK("word count", k0 + 1, n_words)
    `CHK("word a", exp_code(a, p[0], n[0], tw), word_a)
    `CHK("word b", exp_code(b, p[1], n[1], tw), word_b)
    `CHK("mux", mx, mux_seen)
  endtask

  // summary and verdict
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end

  // main sequence
  initial begin
    logic cm, tw, mx;
    {awvalid, wvalid, bready, arvalid, rready, sample_clock} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = '0;
    {raw_a, raw_b, ovr_pos, ovr_neg, fsp, mcp} = '0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(REG_CTRL, rd, rsp);
    `CHK("ctrl reset", {24'h0, CTRL_RST}, rd)
    axi_read(REG_STAT, rd, rsp);
    `CHK("status reset", 32'h0, rd)
    axi_write(4'h8, 32'h0000_00FF, rsp);
    `CHK("unmapped write", RESP_DECERR, rsp)
    axi_read(4'h8, rd, rsp);
    `CHK("unmapped read", RESP_DECERR, rsp)
    `CHK("unmapped data", 32'h0, rd)
    $display("test registers done");
    // sample clock period of 15 cycles (375 ns), 19 in mux mode, below every mode's limit
    for (int m = 0; m < 9; m++) begin
      fsp <= fpt[m];
      mcp <= 3'h7;
      axi_write(REG_CTRL, {24'h0, ctl[m]}, rsp);
      `CHK("ctrl write resp", RESP_OKAY, rsp)
      axi_read(REG_CTRL, rd, rsp);
      `CHK("ctrl readback", {24'h0, ctl[m]}, rd)
      cm = ctl[m][2] ? fpt[m][0] : ctl[m][0];
      tw = ctl[m][2] ? fpt[m][1] : ctl[m][1];
      mx = cm && (ctl[m][2] ? 1'b1 : ctl[m][7:4] == PM_MUX);
      send_check(14'h1234, 14'h0ABC, 2'h0, 2'h0, tw, mx);
      send_check(14'h0555, 14'h2AAA, 2'h1, 2'h2, tw, mx);
      send_check(14'h3000, 14'h0001, 2'h3, 2'h3, tw, mx);
      // idle again: status shows standard and mux of the last word
      axi_read(REG_STAT, rd, rsp);
      `CHK("status", {29'h0, mx, cm, 1'b0}, rd)
      $display("test mode %0d done", m);
    end
    end_of_test;
  end
endmodule
`undef CHK
`default_nettype wire
